//--- rtl/sspfp_pkg.sv
// Package for the serial frame port: frame layout, modes, counts
// Assumes a single system clock domain; link pins are sampled in the block
package sspfp_pkg;
    // ==========================================
    // Frame layout
    localparam int SSPFP_FRAME_BITS = 32; // Bits per frame
    localparam int SSPFP_ADDR_LSB = 0; // Address field low bit
    localparam int SSPFP_ADDR_MSB = 6; // Address field high bit
    localparam int SSPFP_RW_BIT = 7; // Access kind bit
    localparam int SSPFP_DATA_LSB = 8; // Data field low bit
    localparam int SSPFP_DATA_MSB = 23; // Data field high bit
    localparam logic [5:0] SSPFP_CNT_FULL = 6'h20; // Edge count of a whole frame
    localparam logic [5:0] SSPFP_CNT_RST = 6'h00; // Edge count after reset
    localparam logic [31:0] SSPFP_WORD_RST = 32'h00000000; // Word value after reset
    localparam int SSPFP_FIFO_DEPTH = 4; // Received frame buffer depth
    // ==========================================
    // Device modes
    typedef enum logic [2:0] {
        SSPFP_MODE_INIT,
        SSPFP_MODE_NORMAL,
        SSPFP_MODE_STOP,
        SSPFP_MODE_SLEEP,
        SSPFP_MODE_RESTART,
        SSPFP_MODE_FAILSAFE
    } sspfp_mode_t;
    // ==========================================
    // Decoded received frame
    typedef struct packed {
        logic [7:0] spare; // Bits 31..24
        logic [15:0] data; // Bits 23..8
        logic access; // Bit 7
        logic [6:0] addr; // Bits 6..0
    } sspfp_frame_t;
endpackage

//--- rtl/sspfp_fifo.sv
// Small synchronous FIFO for received frames
// Assumes one clock, synchronous active-low reset and a clock enable
`timescale 1ns/1ps
module sspfp_fifo
    import sspfp_pkg::*;
#(
    parameter int WIDTH = 32, // Word width
    parameter int DEPTH = 4 // Entries, power of two
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic clkEn, // Freezes state when low
    input wire logic [WIDTH-1:0] inData, // Write word
    input wire logic inValid, // Write request
    output logic inReady, // Room available
    output logic [WIDTH-1:0] outData, // Head word, registered
    output logic outValid, // Head valid
    input wire logic outReady // Consumer takes head
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW+1:0] FULL_CNT = (AW+2)'(DEPTH); // Words held when full
    // ==========================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH]; // Word store
    logic [AW:0] wrPtr_reg, wrPtr_next; // Write pointer with wrap bit
    logic [AW:0] rdPtr_reg, rdPtr_next; // Read pointer with wrap bit
    logic [WIDTH-1:0] outData_reg, outData_next; // Registered head
    logic outValid_reg, outValid_next; // Head holds a word
    logic doWr; // Write accepted
    logic doLoad; // Head refill
    logic memEmpty; // No word left in store
    logic [AW+1:0] used; // Words held, head register included
    assign memEmpty = (wrPtr_reg == rdPtr_reg);
    // Head register counts as an entry so the whole buffer holds DEPTH words
    assign used = {1'b0, wrPtr_reg - rdPtr_reg} + {{(AW+1){1'b0}}, outValid_reg};
    assign inReady = (used < FULL_CNT);
    assign doWr = inValid && inReady;
    assign doLoad = !memEmpty && (!outValid_reg || outReady);
    // Next pointer and head values
    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        outData_next = outData_reg;
        outValid_next = outValid_reg;
        if (doWr) begin
            wrPtr_next = wrPtr_reg + 1'b1;
        end
        if (doLoad) begin
            outData_next = mem[rdPtr_reg[AW-1:0]];
            rdPtr_next = rdPtr_reg + 1'b1;
            outValid_next = 1'b1;
        end else if (outReady) begin
            outValid_next = 1'b0;
        end
    end
    // Register state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            outData_reg <= '0;
            outValid_reg <= 1'b0;
        end else if (clkEn) begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            outData_reg <= outData_next;
            outValid_reg <= outValid_next;
        end
    end
    // Store words, no reset needed
    always_ff @(posedge clk_sys) begin
        if (clkEn && doWr) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
    assign outData = outData_reg;
    assign outValid = outValid_reg;
endmodule

//--- rtl/sspfp_port.sv
// Serial frame target port: 32-bit full-duplex frames, MSB first
// Assumes link pins come from outside and are synchronised here;
// the link clock is much slower than clk_sys (at least 4 samples per phase)
`timescale 1ns/1ps
module sspfp_port
    import sspfp_pkg::*;
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic clkEn, // Freezes state when low
    input wire sspfp_mode_t devMode, // Current device mode
    input wire logic chip_select_low_n, // Select pin, low active
    input wire logic serClk, // Serial clock pin from master
    input wire logic serIn, // Serial data in pin
    output logic serOut, // Serial data out
    output logic serOutEn, // High while driving serOut
    input wire logic [31:0] txWord, // Response word for next frame
    output logic txTaken, // Pulse: txWord latched at frame start
    output sspfp_frame_t rxFrame, // Received frame head
    output logic rxValid, // Received frame available
    input wire logic rxReady, // Consumer takes frame
    output logic frameErr, // Pulse: bad edge count, frame dropped
    output logic frameDrop // Pulse: good frame lost to full buffer
);
    // ==========================================
    // Pin synchronisers
    logic [2:0] syncA_reg, syncA_next; // First stage: select, clock, data
    logic [2:0] syncB_reg, syncB_next; // Second stage
    logic selLow; // Synced select active
    logic sclk; // Synced clock
    logic sdi; // Synced data
    assign selLow = !syncB_reg[2];
    assign sclk = syncB_reg[1];
    assign sdi = syncB_reg[0];
    // Two-stage capture of the pins
    always_comb begin
        syncA_next = {chip_select_low_n, serClk, serIn};
        syncB_next = syncA_reg;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // Select high, clock at its idle low: no false edge after reset
            syncA_reg <= 3'h5;
            syncB_reg <= 3'h5;
        end else if (clkEn) begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
        end
    end
    // ==========================================
    // Frame engine
    typedef enum logic [0:0] {SSPFP_IDLE, SSPFP_SHIFT} sspfp_state_t;
    sspfp_state_t state_reg, state_next; // Frame state
    logic selPrev_reg, selPrev_next; // Select last cycle
    logic clkPrev_reg, clkPrev_next; // Clock last cycle
    logic [31:0] rxShift_reg, rxShift_next; // Receive shifter
    logic [31:0] txShift_reg, txShift_next; // Transmit shifter
    logic [5:0] fallCnt_reg, fallCnt_next; // Falling edges this frame
    logic [5:0] riseCnt_reg, riseCnt_next; // Rising edges this frame
    logic serOut_reg, serOut_next; // Output bit
    logic serOutEn_reg, serOutEn_next; // Output drive
    logic txTaken_reg, txTaken_next; // Response latch pulse
    logic push_reg, push_next; // Frame push pulse
    logic [31:0] pushWord_reg, pushWord_next; // Frame to buffer
    logic frameErr_reg, frameErr_next; // Error pulse
    logic frameDrop_reg, frameDrop_next; // Drop pulse
    logic portOn; // Mode lets port run
    logic fallEdge; // Clock fell
    logic riseEdge; // Clock rose
    logic fifoReady; // Buffer has room
    logic countOk; // Edge count is whole frame
    assign portOn = (devMode == SSPFP_MODE_INIT) || (devMode == SSPFP_MODE_NORMAL)
        || (devMode == SSPFP_MODE_STOP);
    assign fallEdge = clkPrev_reg && !sclk;
    assign riseEdge = !clkPrev_reg && sclk;
    // Idle-low clock: every fall has its own rise, so a whole frame is 32 of each
    assign countOk = (fallCnt_reg == SSPFP_CNT_FULL) && (riseCnt_reg == SSPFP_CNT_FULL);
    // Next frame state
    always_comb begin
        state_next = state_reg;
        selPrev_next = selLow;
        clkPrev_next = sclk;
        rxShift_next = rxShift_reg;
        txShift_next = txShift_reg;
        fallCnt_next = fallCnt_reg;
        riseCnt_next = riseCnt_reg;
        serOut_next = serOut_reg;
        serOutEn_next = serOutEn_reg;
        txTaken_next = 1'b0;
        push_next = 1'b0;
        pushWord_next = pushWord_reg;
        frameErr_next = 1'b0;
        frameDrop_next = 1'b0;
        case (state_reg)
            SSPFP_IDLE: begin
                serOutEn_next = 1'b0;
                if (portOn && selLow && !selPrev_reg) begin
                    // Select fell: start frame, load response MSB first
                    state_next = SSPFP_SHIFT;
                    txShift_next = {txWord[30:0], 1'b0};
                    serOut_next = txWord[31];
                    serOutEn_next = 1'b1;
                    txTaken_next = 1'b1;
                    fallCnt_next = SSPFP_CNT_RST;
                    riseCnt_next = SSPFP_CNT_RST;
                end
            end
            SSPFP_SHIFT: begin
                if (!portOn) begin
                    // Mode left: abandon frame silently
                    state_next = SSPFP_IDLE;
                    serOutEn_next = 1'b0;
                end else if (!selLow) begin
                    // Select rose: release output, judge word
                    state_next = SSPFP_IDLE;
                    serOutEn_next = 1'b0;
                    if (countOk) begin
                        push_next = fifoReady;
                        frameDrop_next = !fifoReady;
                        pushWord_next = rxShift_reg;
                    end else if (fallCnt_reg != SSPFP_CNT_RST || riseCnt_reg != SSPFP_CNT_RST) begin
                        frameErr_next = 1'b1;
                    end
                end else begin
                    if (fallEdge) begin
                        // Sample input bit, own bits only
                        rxShift_next = {rxShift_reg[30:0], sdi};
                        if (fallCnt_reg != 6'h3F) begin
                            fallCnt_next = fallCnt_reg + 6'h1;
                        end
                    end
                    if (riseEdge) begin
                        // Present next response bit
                        serOut_next = txShift_reg[31];
                        txShift_next = {txShift_reg[30:0], 1'b0};
                        if (riseCnt_reg != 6'h3F) begin
                            riseCnt_next = riseCnt_reg + 6'h1;
                        end
                    end
                end
            end
            default: begin
                state_next = SSPFP_IDLE;
                serOutEn_next = 1'b0;
            end
        endcase
    end
    // Register frame state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= SSPFP_IDLE;
            selPrev_reg <= 1'b0;
            clkPrev_reg <= 1'b0;
            rxShift_reg <= SSPFP_WORD_RST;
            txShift_reg <= SSPFP_WORD_RST;
            fallCnt_reg <= SSPFP_CNT_RST;
            riseCnt_reg <= SSPFP_CNT_RST;
            serOut_reg <= 1'b0;
            serOutEn_reg <= 1'b0;
            txTaken_reg <= 1'b0;
            push_reg <= 1'b0;
            pushWord_reg <= SSPFP_WORD_RST;
            frameErr_reg <= 1'b0;
            frameDrop_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
            selPrev_reg <= selPrev_next;
            clkPrev_reg <= clkPrev_next;
            rxShift_reg <= rxShift_next;
            txShift_reg <= txShift_next;
            fallCnt_reg <= fallCnt_next;
            riseCnt_reg <= riseCnt_next;
            serOut_reg <= serOut_next;
            serOutEn_reg <= serOutEn_next;
            txTaken_reg <= txTaken_next;
            push_reg <= push_next;
            pushWord_reg <= pushWord_next;
            frameErr_reg <= frameErr_next;
            frameDrop_reg <= frameDrop_next;
        end
    end
    // ==========================================
    // Received frame buffer
    logic [31:0] headWord; // Buffer head
    sspfp_fifo #(.WIDTH(SSPFP_FRAME_BITS), .DEPTH(SSPFP_FIFO_DEPTH)) uFifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inData(pushWord_reg),
        .inValid(push_reg),
        .inReady(fifoReady),
        .outData(headWord),
        .outValid(rxValid),
        .outReady(rxReady)
    );
    assign rxFrame = sspfp_frame_t'(headWord);
    assign serOut = serOut_reg;
    assign serOutEn = serOutEn_reg;
    assign txTaken = txTaken_reg;
    assign frameErr = frameErr_reg;
    assign frameDrop = frameDrop_reg;
    // ==========================================
    // Checks
    sequence s_selRise;
        clkEn && state_reg == SSPFP_SHIFT && portOn && !selLow;
    endsequence
    property p_release;
        @(posedge clk_sys) disable iff (!rst_n) s_selRise |=> !serOutEn;
    endproperty
    a_release: assert property (p_release) else $error("output not released");
    property p_offMode;
        @(posedge clk_sys) disable iff (!rst_n) (clkEn && !portOn) |=> !serOutEn;
    endproperty
    a_offMode: assert property (p_offMode) else $error("port active when off");
    property p_errCount;
        @(posedge clk_sys) disable iff (!rst_n)
            (s_selRise ##0 (fallCnt_reg == SSPFP_CNT_FULL - 6'h1)) |=> frameErr && !push_reg;
    endproperty
    a_errCount: assert property (p_errCount) else $error("short frame not flagged");
    property p_pushOnlyFull;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(push_reg) |-> $past(fallCnt_reg) == SSPFP_CNT_FULL;
    endproperty
    a_pushOnlyFull: assert property (p_pushOnlyFull) else $error("partial word used");
    property p_pushAfterSel;
        @(posedge clk_sys) disable iff (!rst_n) push_reg |-> !selLow && $past(selLow, 2);
    endproperty
    a_pushAfterSel: assert property (p_pushAfterSel) else $error("push inside frame");
    property p_start;
        @(posedge clk_sys) disable iff (!rst_n)
            (clkEn && state_reg == SSPFP_IDLE && portOn && selLow && !selPrev_reg)
            |=> serOutEn && txTaken && serOut == $past(txWord[31]);
    endproperty
    a_start: assert property (p_start) else $error("frame start wrong");
    property p_sample;
        @(posedge clk_sys) disable iff (!rst_n)
            (clkEn && state_reg == SSPFP_SHIFT && portOn && selLow && fallEdge)
            |=> rxShift_reg[0] == $past(sdi);
    endproperty
    a_sample: assert property (p_sample) else $error("input not sampled");
    property p_shiftOut;
        @(posedge clk_sys) disable iff (!rst_n)
            (clkEn && state_reg == SSPFP_SHIFT && portOn && selLow && riseEdge)
            |=> serOut == $past(txShift_reg[31]);
    endproperty
    a_shiftOut: assert property (p_shiftOut) else $error("output not advanced");
endmodule

//--- test/sspfp_host_model.sv
// Host model: the bus master that drives select, link clock and data
// Assumes clk_sys paces it; half a link period is 4 cycles (400 ns period)
`timescale 1ns/1ps
module sspfp_host_model (
    input wire logic clk_sys, // Pacing clock
    input wire logic busLine, // Resolved target data line
    output logic chipSelectLowN, // Select, low active
    output logic serClk, // Link clock, idle low
    output logic serIn // Data to the target
);
    // ==========================================
    // Master behaviour
    initial begin
        chipSelectLowN = 1'b1; // Deselected
        serClk = 1'b0; // Clock stands still
        serIn = 1'b0; // Data idle
    end
    // Select our one target by its own line
    task automatic begin_frame();
        @(negedge clk_sys);
        chipSelectLowN = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
    // Shift n bits, answer sampled just before each rise
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            serIn = tx[31-i];
            repeat (2) @(negedge clk_sys);
            rx = {rx[30:0], busLine};
            serClk = 1'b1;
            repeat (4) @(negedge clk_sys);
            serClk = 1'b0;
            repeat (2) @(negedge clk_sys);
        end
    endtask
    // Release select with the clock low; data line shows a stale-breaking value
    task automatic end_frame();
        repeat (2) @(negedge clk_sys);
        chipSelectLowN = 1'b1;
        serIn = ~serIn; // Released data does not keep its last bit
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

//--- test/test_spi_slave_frame_port.sv
// Testbench for the serial frame target port
// Assumes the host model drives the link; bench drives the rest at falling edges
`timescale 1ns/1ps
module test_spi_slave_frame_port;
    import sspfp_pkg::*;
    // ==========================================
    // Signals
    logic clk_sys, rst_n, clkEn, rxReady, sawEn; // Bench side
    logic chipSelectLowN, serClk, serIn, serOut, serOutEn; // Link
    logic txTaken, rxValid, frameErr, frameDrop; // Status
    logic [31:0] txWord; // Response word
    sspfp_mode_t devMode; // Device mode
    sspfp_frame_t rxFrame; // Received head
    int n_fail, total_checks, nTaken, nErr, nDrop; // Counters
    wire busLine = serOutEn ? serOut : 1'bz; // Released line floats
    sspfp_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .devMode(devMode),
        .chip_select_low_n(chipSelectLowN), .serClk(serClk), .serIn(serIn),
        .serOut(serOut), .serOutEn(serOutEn), .txWord(txWord), .txTaken(txTaken),
        .rxFrame(rxFrame), .rxValid(rxValid), .rxReady(rxReady), .frameErr(frameErr),
        .frameDrop(frameDrop));
    sspfp_host_model Host (.clk_sys(clk_sys), .busLine(busLine),
        .chipSelectLowN(chipSelectLowN), .serClk(serClk), .serIn(serIn));
    // ==========================================
    // Clock, pulse counters, watchdog
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (txTaken === 1'b1) nTaken++; // Latch pulses
        if (frameErr === 1'b1) nErr++;
        if (frameDrop === 1'b1) nDrop++;
        if (serOutEn === 1'b1) sawEn = 1'b1;
    end
    initial begin
        #2000000;
        n_fail++; // Hang counts as a mismatch
        finish_test();
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clear_flags();
        nTaken = 0;
        nErr = 0;
        nDrop = 0;
        sawEn = 1'b0;
    endtask
    task automatic do_frame(input logic [31:0] tx, input int n);
        logic [31:0] rx;
        Host.begin_frame();
        Host.shift(tx, n, rx);
        Host.end_frame();
    endtask
    // Wait for a frame, compare it, take it
    task automatic pop(input logic [31:0] exp);
        int k = 0;
        while (rxValid !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        chk("valid at pop", 32'h1, 32'(rxValid));
        chk("received frame", exp, rxFrame);
        rxReady = 1'b1;
        @(negedge clk_sys);
        rxReady = 1'b0;
        @(negedge clk_sys);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_basic();
        logic [31:0] rx;
        logic [31:0] w = 32'h00BEEF85;
        clear_flags();
        txWord = 32'hA5C31E7F;
        Host.begin_frame();
        chk("txTaken pulses", 32'h1, 32'(nTaken));
        chk("enable in frame", 32'h1, 32'(serOutEn));
        Host.shift(w, 32, rx);
        chk("valid before release", 32'h0, 32'(rxValid));
        Host.end_frame();
        chk("returned word", 32'hA5C31E7F, rx);
        chk("enable after release", 32'h0, 32'(serOutEn));
        chk("address", 32'(w[SSPFP_ADDR_MSB:SSPFP_ADDR_LSB]), 32'(rxFrame.addr));
        chk("access", 32'(w[SSPFP_RW_BIT]), 32'(rxFrame.access));
        chk("data", 32'(w[SSPFP_DATA_MSB:SSPFP_DATA_LSB]), 32'(rxFrame.data));
        pop(w);
        sawEn = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk("enable while idle", 32'h0, 32'(sawEn));
    endtask
    // Every mode: port runs in the first three only
    task automatic t_modes();
        logic on;
        for (int m = 0; m < 6; m++) begin
            devMode = sspfp_mode_t'(m);
            on = (m < 3);
            clear_flags();
            do_frame(32'h00123400 | 32'(m), 32);
            chk("valid per mode", 32'(on), 32'(rxValid));
            chk("enable per mode", 32'(on), 32'(sawEn));
            if (on) pop(32'h00123400 | 32'(m));
        end
        devMode = SSPFP_MODE_NORMAL;
    endtask
    // Short frame flagged and dropped; empty frame silent
    task automatic t_badcount();
        clear_flags();
        do_frame(32'h00FACE01, 31);
        chk("error on 31", 32'h1, 32'(nErr));
        chk("no frame on 31", 32'h0, 32'(rxValid));
        clear_flags();
        do_frame(32'h00FACE01, 0);
        chk("no error on 0", 32'h0, 32'(nErr));
        chk("no frame on 0", 32'h0, 32'(rxValid));
    endtask
    // Frame cut by a mode change, then a frame while frozen: both leave no trace
    task automatic t_offmid();
        logic [31:0] rx;
        clear_flags();
        Host.begin_frame();
        Host.shift(32'h00ABCD12, 8, rx);
        devMode = SSPFP_MODE_SLEEP;
        repeat (4) @(negedge clk_sys);
        chk("enable after mode left", 32'h0, 32'(serOutEn));
        Host.shift(32'h00ABCD12, 24, rx);
        Host.end_frame();
        devMode = SSPFP_MODE_NORMAL;
        chk("no error on abort", 32'h0, 32'(nErr));
        chk("no frame on abort", 32'h0, 32'(rxValid));
        clear_flags();
        clkEn = 1'b0;
        do_frame(32'h00ABCD12, 32);
        clkEn = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("frozen frame", 32'h0, 32'(nTaken + nErr + int'(rxValid) + int'(sawEn)));
    endtask
    // Fill buffer with consumer stalled, then drain in order
    task automatic t_fifo();
        clear_flags();
        for (int k = 0; k < 5; k++) do_frame(32'h00C0DE00 | 32'(k), 32);
        chk("drop on full", 32'h1, 32'(nDrop));
        for (int k = 0; k < SSPFP_FIFO_DEPTH; k++) pop(32'h00C0DE00 | 32'(k));
        chk("empty after drain", 32'h0, 32'(rxValid));
    endtask
    // ==========================================
    // Verdict and main sequence
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        n_fail = 0;
        total_checks = 0;
        clear_flags();
        rst_n = 1'b0;
        clkEn = 1'b1;
        rxReady = 1'b0;
        txWord = 32'h00000000;
        devMode = SSPFP_MODE_NORMAL;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_basic();
        t_modes();
        t_badcount();
        t_offmid();
        t_fifo();
        finish_test();
    end
endmodule
